// ==== line_ctl_pkg.sv ====
// constants shared by the line interface control register bank
package line_ctl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] CTL_ONE_IDX = 8'h10;
    localparam logic [7:0] CTL_TWO_IDX = 8'h11;
    localparam logic [11:0] CTL_ONE_ADDR = 12'h040;
    localparam logic [11:0] CTL_TWO_ADDR = 12'h044;
    localparam logic [11:0] STATUS_ADDR = 12'h048;

    // reset values
    localparam logic [7:0] CTL_ONE_RESET = 8'h08;
    localparam logic [7:0] CTL_TWO_RESET = 8'h00;

    // writable bit masks, reserved bits cleared
    localparam logic [7:0] CTL_ONE_WMASK = 8'hEF;
    localparam logic [7:0] CTL_TWO_WMASK = 8'h7F;

    // control one field positions
    localparam int OFF_SQUELCH_BIT = 7;
    localparam int ON_HOOK_SPEED_BIT = 6;
    localparam int AC_TERM_BIT = 5;
    localparam int DC_TERM_LSB = 2;
    localparam int RINGER_IMP_BIT = 1;
    localparam int RING_THRESH_BIT = 0;

    // control two field positions
    localparam int MANUAL_CAL_BIT = 6;
    localparam int AUTOCAL_DIS_BIT = 5;
    localparam int CLAMP_EN_BIT = 4;
    localparam int OVERLOAD_EN_BIT = 3;

    // off-hook counter lengths in sample periods
    localparam int FAST_ONHOOK_SAMPLES = 1024;
    localparam int SLOW_ONHOOK_SAMPLES = 4096;

    // ring detection windows, volts rms
    localparam logic [5:0] RING_LOW_MIN_V = 6'h0B;
    localparam logic [5:0] RING_LOW_MAX_V = 6'h16;
    localparam logic [5:0] RING_HIGH_MIN_V = 6'h11;
    localparam logic [5:0] RING_HIGH_MAX_V = 6'h21;

    // dc termination modes
    typedef enum logic [1:0] {
        DC_LOW_VOLTAGE = 2'h0,
        DC_LOWER_VOLTAGE = 2'h1,
        DC_STANDARD = 2'h2,
        DC_CURRENT_LIMIT = 2'h3
    } dc_term_mode_t;

    // transmit level magnitudes, negative dBm
    localparam logic [2:0] TX_LEVEL_LOW = 3'h5;
    localparam logic [2:0] TX_LEVEL_LOWER = 3'h3;
    localparam logic [2:0] TX_LEVEL_STD = 3'h1;
endpackage : line_ctl_pkg

// ==== onhook_timer.sv ====
// off-hook counter that holds the line during an on-hook release
`timescale 1ns/1ps
module onhook_timer #(
    parameter int FAST_COUNT = line_ctl_pkg::FAST_ONHOOK_SAMPLES,
    parameter int SLOW_COUNT = line_ctl_pkg::SLOW_ONHOOK_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sample rate strobe and controls
    input wire logic sample_tick,
    input wire logic off_hook_req,
    input wire logic slow_mode,
    // status
    output logic line_held_r,
    output logic releasing_r
);
    localparam int CW = $clog2(SLOW_COUNT + 1);

    initial begin
        if (FAST_COUNT < 1 || SLOW_COUNT < FAST_COUNT) begin
            $error("onhook_timer: bad counter lengths");
        end
    end

    typedef enum logic [1:0] {ON_HOOK, OFF_HOOK, RELEASE} hook_state_t;

    hook_state_t state_r;
    logic [CW-1:0] count_r;

    // hook sequencing; speed is latched when release starts
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ON_HOOK;
            count_r <= '0;
        end else begin
            case (state_r)
                ON_HOOK: begin
                    if (off_hook_req) begin
                        state_r <= OFF_HOOK;
                    end
                end
                OFF_HOOK: begin
                    if (!off_hook_req) begin
                        state_r <= RELEASE;
                        if (slow_mode) begin
                            count_r <= CW'(SLOW_COUNT);
                        end else begin
                            count_r <= CW'(FAST_COUNT);
                        end
                    end
                end
                RELEASE: begin
                    // a new request aborts the release
                    if (off_hook_req) begin
                        state_r <= OFF_HOOK;
                    end else if (sample_tick) begin
                        if (count_r == CW'(1)) begin
                            state_r <= ON_HOOK;
                        end
                        count_r <= count_r - CW'(1);
                    end
                end
                default: begin
                    state_r <= ON_HOOK;
                end
            endcase
        end
    end

    // registered status, one cycle behind the state
    always_ff @(posedge clk) begin
        if (reset) begin
            line_held_r <= 1'b0;
            releasing_r <= 1'b0;
        end else begin
            line_held_r <= (state_r != ON_HOOK);
            releasing_r <= (state_r == RELEASE);
        end
    end
endmodule : onhook_timer

// ==== line_interface_control_regs.sv ====
// apb register bank and decode for the line interface controls
//
// What this block does
// - on-hook speed clear gives fast on-hook, counter 1024 sample periods.
// - on-hook speed set gives slow on-hook, counter 4096 sample periods.
// - ac termination bit 5 picks real (0) or complex (1) impedance.
// - dc termination bits 3:2 pick mode and transmit level -5,-3,-1,-1 dBm.
// - ringer impedance bit 1 picks high (0) or synthesized (1) impedance.
// - ring threshold bit 0 picks 11-22 V or 17-33 V ring window.
// - control two resets to zero; bit 7 reserved, bits 6:0 read/write.
// - control one resets to 0000-1000.
`timescale 1ns/1ps
module line_interface_control_regs #(
    parameter int FAST_COUNT = line_ctl_pkg::FAST_ONHOOK_SAMPLES,
    parameter int SLOW_COUNT = line_ctl_pkg::SLOW_ONHOOK_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line side inputs
    input wire logic sample_tick,
    input wire logic off_hook_req,
    input wire logic [5:0] ring_level_vrms,
    // line side controls
    output logic line_held,
    output logic off_squelch,
    output logic ac_term_complex,
    output logic [1:0] dc_termination_mode,
    output logic [2:0] tx_level_neg_dbm,
    output logic dc_current_limit,
    output logic ringer_impedance_select,
    output logic [5:0] ring_min_vrms,
    output logic [5:0] ring_max_vrms,
    output logic ring_detected,
    // control two fields
    output logic manual_calibration,
    output logic autocal_disable,
    output logic current_clamp_enable,
    output logic overload_protect_enable,
    output logic [2:0] ctl_two_low
);
    logic [7:0] ctl_one_r;
    logic [7:0] ctl_two_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0] rd_nxt;
    logic hit_one;
    logic hit_two;
    logic hit_status;
    logic mapped;
    logic access_end;
    logic timer_held;
    logic timer_releasing;

    // the counter must be able to load both lengths; a slow length
    // below the fast one would make the slow on-hook the quicker one
    initial begin
        if (FAST_COUNT < 1 || SLOW_COUNT < FAST_COUNT) begin
            $error("line_interface_control_regs: bad counter lengths");
        end
    end

    // address decode
    assign hit_one = (paddr == line_ctl_pkg::CTL_ONE_ADDR);
    assign hit_two = (paddr == line_ctl_pkg::CTL_TWO_ADDR);
    assign hit_status = (paddr == line_ctl_pkg::STATUS_ADDR);
    assign mapped = hit_one | hit_two | hit_status;
    // the edge at which the master samples pready high
    assign access_end = psel & penable & pready_r;

    // read mux; reserved bits come back as zero
    always_comb begin
        rd_nxt = 8'h00;
        if (hit_one) begin
            rd_nxt = ctl_one_r & line_ctl_pkg::CTL_ONE_WMASK;
        end else if (hit_two) begin
            rd_nxt = ctl_two_r & line_ctl_pkg::CTL_TWO_WMASK;
        end else if (hit_status) begin
            rd_nxt = {6'h00, timer_releasing, timer_held};
        end
    end

    // one wait state: answer registered so outputs come from flops
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= ~mapped;
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end

    // control one; bit 4 masked so writes to it are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_one_r <= line_ctl_pkg::CTL_ONE_RESET;
        end else if (access_end && pwrite && hit_one && pstrb[0]) begin
            ctl_one_r <= pwdata[7:0] & line_ctl_pkg::CTL_ONE_WMASK;
        end
    end

    // control two; reserved bit 7 forced low
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_two_r <= line_ctl_pkg::CTL_TWO_RESET;
        end else if (access_end && pwrite && hit_two && pstrb[0]) begin
            ctl_two_r <= pwdata[7:0] & line_ctl_pkg::CTL_TWO_WMASK;
        end
    end

    // off-hook counter, speed taken from control one
    onhook_timer #(
        .FAST_COUNT(FAST_COUNT),
        .SLOW_COUNT(SLOW_COUNT)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .sample_tick(sample_tick),
        .off_hook_req(off_hook_req),
        .slow_mode(ctl_one_r[line_ctl_pkg::ON_HOOK_SPEED_BIT]),
        .line_held_r(timer_held),
        .releasing_r(timer_releasing)
    );

    // bit 7 is stored only; its meaning depends on the hook state,
    // which the logic outside this bank knows
    always_ff @(posedge clk) begin
        if (reset) begin
            off_squelch <= 1'b0;
        end else begin
            off_squelch <= ctl_one_r[line_ctl_pkg::OFF_SQUELCH_BIT];
        end
    end

    // ac termination: 0 real, 1 complex impedance
    always_ff @(posedge clk) begin
        if (reset) begin
            ac_term_complex <= 1'b0;
        end else begin
            ac_term_complex <= ctl_one_r[line_ctl_pkg::AC_TERM_BIT];
        end
    end

    // dc termination mode as written; lags the register by one clock,
    // so right after reset it shows zero for a single cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            dc_termination_mode <= 2'h0;
        end else begin
            dc_termination_mode <=
                ctl_one_r[line_ctl_pkg::DC_TERM_LSB +: 2];
        end
    end

    // transmit level per mode; the current limiting mode shares the
    // standard level, so it falls into the default branch
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_level_neg_dbm <= 3'h0;
        end else begin
            case (line_ctl_pkg::dc_term_mode_t'(
                    ctl_one_r[line_ctl_pkg::DC_TERM_LSB +: 2]))
                line_ctl_pkg::DC_LOW_VOLTAGE: begin
                    tx_level_neg_dbm <= line_ctl_pkg::TX_LEVEL_LOW;
                end
                line_ctl_pkg::DC_LOWER_VOLTAGE: begin
                    tx_level_neg_dbm <= line_ctl_pkg::TX_LEVEL_LOWER;
                end
                default: begin
                    tx_level_neg_dbm <= line_ctl_pkg::TX_LEVEL_STD;
                end
            endcase
        end
    end

    // current limiting flag, high only in the last mode
    always_ff @(posedge clk) begin
        if (reset) begin
            dc_current_limit <= 1'b0;
        end else begin
            dc_current_limit <= (ctl_one_r[line_ctl_pkg::DC_TERM_LSB +: 2]
                == line_ctl_pkg::DC_CURRENT_LIMIT);
        end
    end

    // ringer impedance: 0 high, 1 synthesized; the synthesized setting
    // assumes the external ringer parts are left off the board
    always_ff @(posedge clk) begin
        if (reset) begin
            ringer_impedance_select <= 1'b0;
        end else begin
            ringer_impedance_select <=
                ctl_one_r[line_ctl_pkg::RINGER_IMP_BIT];
        end
    end

    // hook status; one more flop so the pin comes straight from here,
    // at the cost of one extra cycle of delay
    always_ff @(posedge clk) begin
        if (reset) begin
            line_held <= 1'b0;
        end else begin
            line_held <= timer_held;
        end
    end

    // ring window bounds follow the threshold bit
    always_ff @(posedge clk) begin
        if (reset) begin
            ring_min_vrms <= line_ctl_pkg::RING_LOW_MIN_V;
            ring_max_vrms <= line_ctl_pkg::RING_LOW_MAX_V;
        end else if (ctl_one_r[line_ctl_pkg::RING_THRESH_BIT]) begin
            ring_min_vrms <= line_ctl_pkg::RING_HIGH_MIN_V;
            ring_max_vrms <= line_ctl_pkg::RING_HIGH_MAX_V;
        end else begin
            ring_min_vrms <= line_ctl_pkg::RING_LOW_MIN_V;
            ring_max_vrms <= line_ctl_pkg::RING_LOW_MAX_V;
        end
    end

    // detect at the lower bound so nothing below it flags
    // and everything above the upper bound always does
    always_ff @(posedge clk) begin
        if (reset) begin
            ring_detected <= 1'b0;
        end else if (ctl_one_r[line_ctl_pkg::RING_THRESH_BIT]) begin
            ring_detected <=
                (ring_level_vrms >= line_ctl_pkg::RING_HIGH_MIN_V);
        end else begin
            ring_detected <=
                (ring_level_vrms >= line_ctl_pkg::RING_LOW_MIN_V);
        end
    end

    // manual calibration request
    always_ff @(posedge clk) begin
        if (reset) begin
            manual_calibration <= 1'b0;
        end else begin
            manual_calibration <= ctl_two_r[line_ctl_pkg::MANUAL_CAL_BIT];
        end
    end

    // automatic calibration disable
    always_ff @(posedge clk) begin
        if (reset) begin
            autocal_disable <= 1'b0;
        end else begin
            autocal_disable <= ctl_two_r[line_ctl_pkg::AUTOCAL_DIS_BIT];
        end
    end

    // current clamp enable, only of use in the current limiting mode
    always_ff @(posedge clk) begin
        if (reset) begin
            current_clamp_enable <= 1'b0;
        end else begin
            current_clamp_enable <= ctl_two_r[line_ctl_pkg::CLAMP_EN_BIT];
        end
    end

    // overload protection enable
    always_ff @(posedge clk) begin
        if (reset) begin
            overload_protect_enable <= 1'b0;
        end else begin
            overload_protect_enable <=
                ctl_two_r[line_ctl_pkg::OVERLOAD_EN_BIT];
        end
    end

    // low three bits passed through as stored;
    // their meaning lies outside this bank
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_two_low <= 3'h0;
        end else begin
            ctl_two_low <= ctl_two_r[2:0];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
endmodule : line_interface_control_regs

// ==== line_interface_control_regs_sva.sv ====
// checker of apb timing and decoded outputs of the control bank
`timescale 1ns/1ps
module line_interface_control_regs_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line side
    input wire logic off_hook_req,
    input wire logic line_held,
    input wire logic [1:0] dc_termination_mode,
    input wire logic [2:0] tx_level_neg_dbm,
    input wire logic dc_current_limit,
    input wire logic [5:0] ring_min_vrms,
    input wire logic [5:0] ring_max_vrms
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // apb answer is a single pulse after exactly one wait state
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    wait_state_a: assert property (
        pready |-> psel && penable && $past(penable))
        else $error("pready without setup and wait state");
    read_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside an answer");
    slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    // decode guarded one edge past reset, since decode lags the register
    tx_level_a: assert property (
        !$past(reset) |-> tx_level_neg_dbm == (dc_termination_mode == 2'h0 ?
        3'h5 : (dc_termination_mode == 2'h1 ? 3'h3 : 3'h1)))
        else $error("transmit level does not match dc mode");
    current_limit_a: assert property (
        !$past(reset) |-> dc_current_limit == (dc_termination_mode == 2'h3))
        else $error("current limit does not match dc mode");
    ring_window_a: assert property (
        (ring_min_vrms == 6'h0B && ring_max_vrms == 6'h16) ||
        (ring_min_vrms == 6'h11 && ring_max_vrms == 6'h21))
        else $error("ring window bounds inconsistent");
    hold_start_a: assert property (
        $rose(off_hook_req) |-> ##3 line_held)
        else $error("line not held three cycles after request");
endmodule : line_interface_control_regs_sva

bind line_interface_control_regs line_interface_control_regs_sva
    line_interface_control_regs_sva_i (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .off_hook_req(off_hook_req), .line_held(line_held),
    .dc_termination_mode(dc_termination_mode),
    .tx_level_neg_dbm(tx_level_neg_dbm), .dc_current_limit(dc_current_limit),
    .ring_min_vrms(ring_min_vrms), .ring_max_vrms(ring_max_vrms));

// ==== line_interface_control_regs_tb.sv ====
// self-checking bench for the line interface control register bank
`timescale 1ns/1ps
module line_interface_control_regs_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err;
    logic sample_tick = 1'b0, off_hook_req = 1'b0;
    logic [5:0] ring_level_vrms = 6'h00, ring_min_vrms, ring_max_vrms;
    logic line_held, off_squelch, ac_term_complex, dc_current_limit;
    logic ringer_impedance_select, ring_detected, manual_calibration;
    logic autocal_disable, current_clamp_enable, overload_protect_enable;
    logic [1:0] dc_termination_mode;
    logic [2:0] tx_level_neg_dbm, ctl_two_low;
    int err_total = 0, checked = 0, cycles = 0;
    logic [2:0] tx_exp [4] = '{3'h5, 3'h3, 3'h1, 3'h1};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    line_interface_control_regs #(.FAST_COUNT(4), .SLOW_COUNT(8))
    line_interface_control_regs_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_tick(sample_tick), .off_hook_req(off_hook_req),
        .ring_level_vrms(ring_level_vrms), .line_held(line_held),
        .off_squelch(off_squelch), .ac_term_complex(ac_term_complex),
        .dc_termination_mode(dc_termination_mode),
        .tx_level_neg_dbm(tx_level_neg_dbm),
        .dc_current_limit(dc_current_limit),
        .ringer_impedance_select(ringer_impedance_select),
        .ring_min_vrms(ring_min_vrms), .ring_max_vrms(ring_max_vrms),
        .ring_detected(ring_detected),
        .manual_calibration(manual_calibration),
        .autocal_disable(autocal_disable),
        .current_clamp_enable(current_clamp_enable),
        .overload_protect_enable(overload_protect_enable),
        .ctl_two_low(ctl_two_low));

    task finish_test;
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // a hang ends the run with a mismatch counted
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task check_val(input string name, input logic [31:0] exp,
                   input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // one apb transfer; answer taken at the edge where pready is high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // release from off hook, counting n sample ticks
    task hook(input int n);
        off_hook_req <= 1'b1;
        wait_cyc(4);
        check_val("held", 1, line_held);
        off_hook_req <= 1'b0;
        repeat (n) begin
            wait_cyc(3);
            check_val("held_count", 1, line_held);
            sample_tick <= 1'b1;
            wait_cyc(1);
            sample_tick <= 1'b0;
        end
        wait_cyc(4);
        check_val("released", 0, line_held);
    endtask : hook

    initial begin
        wait_cyc(20);
        reset <= 1'b0;
        wait_cyc(3);
        check_val("mode_rst", 2, dc_termination_mode);
        check_val("tx_rst", 1, tx_level_neg_dbm);
        check_val("rmin_rst", 11, ring_min_vrms);
        check_val("sq_rst", 0, off_squelch);
        apb(1'b0, line_ctl_pkg::CTL_ONE_ADDR, 32'h0);
        check_val("one_rst", 32'h08, rd);
        apb(1'b0, line_ctl_pkg::CTL_TWO_ADDR, 32'h0);
        check_val("two_rst", 32'h00, rd);
        ring_level_vrms <= 6'h0B;
        wait_cyc(3);
        check_val("ring11", 1, ring_detected);
        ring_level_vrms <= 6'h0A;
        wait_cyc(3);
        check_val("ring10", 0, ring_detected);
        hook(4);
        apb(1'b1, line_ctl_pkg::CTL_ONE_ADDR, 32'hFF);
        apb(1'b0, line_ctl_pkg::CTL_ONE_ADDR, 32'h0);
        check_val("one_rsv", 32'hEF, rd);
        check_val("ac", 1, ac_term_complex);
        check_val("rz", 1, ringer_impedance_select);
        check_val("rmax", 33, ring_max_vrms);
        check_val("rmin", 17, ring_min_vrms);
        check_val("climit", 1, dc_current_limit);
        ring_level_vrms <= 6'h11;
        wait_cyc(3);
        check_val("ring17", 1, ring_detected);
        ring_level_vrms <= 6'h10;
        wait_cyc(3);
        check_val("ring16", 0, ring_detected);
        hook(8);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, line_ctl_pkg::CTL_ONE_ADDR, 32'(m) << 2);
            wait_cyc(3);
            check_val("mode", 32'(m), dc_termination_mode);
            check_val("tx", tx_exp[m], tx_level_neg_dbm);
            check_val("ac_off", 0, ac_term_complex);
            check_val("rz_off", 0, ringer_impedance_select);
        end
        apb(1'b1, line_ctl_pkg::CTL_TWO_ADDR, 32'hFF);
        apb(1'b0, line_ctl_pkg::CTL_TWO_ADDR, 32'h0);
        check_val("two_rsv", 32'h7F, rd);
        check_val("two_f", 32'hF, {manual_calibration, autocal_disable,
            current_clamp_enable, overload_protect_enable});
        check_val("two_low", 7, ctl_two_low);
        // a write without its low byte strobe must leave the register
        pstrb <= 4'h0;
        apb(1'b1, line_ctl_pkg::CTL_TWO_ADDR, 32'h00);
        pstrb <= 4'hF;
        apb(1'b0, line_ctl_pkg::CTL_TWO_ADDR, 32'h0);
        check_val("two_strb", 32'h7F, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        check_val("unmap_err", 1, err);
        check_val("unmap_rd", 0, rd);
        finish_test();
    end
endmodule : line_interface_control_regs_tb
